/* shared/bcd_alu_map.svh */
`ifndef BCD_ALU_MAP_SVH
`define BCD_ALU_MAP_SVH
// register byte offsets on the plain register port
`define OFS_ACCUMULATOR 8'h00
`define OFS_FLAGS 8'h04
`define OFS_EVENT_STATUS 8'h08
`define OFS_EVENT_CLEAR 8'h0c
`define OFS_EVENT_ENABLE 8'h10
// bit positions inside the flags register
`define FLG_LESS 0
`define FLG_EQUAL 1
`define FLG_GREATER 2
`define FLG_ZERO 3
`define FLG_BORROW16 4
`define FLG_BORROW32 5
`define FLG_CARRY16 6
`define FLG_CARRY32 7
`define FLG_NEGATIVE 8
`define FLG_BAD_DIGIT 9
`define FLAGS_WIDTH 10
// bit positions inside the event status, clear and enable registers
`define EVT_DONE 0
`define EVT_OVERFLOW 1
`define EVT_BAD_DIGIT 2
`define EVT_WIDTH 3
// reset values
`define ACC_RESET 32'h0000_0000
`define FLAGS_RESET 10'h000
`define EVENT_RESET 3'h0
`define RDATA_RESET 32'h0000_0000
`endif

/* shared/bcd_alu_pkg.sv */
package bcd_alu_pkg;
    // operations the sequencer may issue with a strobe
    typedef enum logic [2:0] {
        COMPARE_DOUBLE_OP,
        BCD_ADD_SINGLE_OP,
        BCD_ADD_DOUBLE_OP,
        BCD_SUBTRACT_SINGLE_OP,
        BCD_SUBTRACT_DOUBLE_OP
    } op_t;
    // one accumulator or operand word
    typedef logic [31:0] word_t;
endpackage

/* core/bcd_digit_adder.sv */
`timescale 1ns/100ps
// ripple of decimal digit cells; subtract adds the nines complement plus one
module bcd_digit_adder #(
    parameter int DIGITS = 8
) (
    input wire logic [4*DIGITS-1:0] augend,
    input wire logic [4*DIGITS-1:0] addend,
    input wire logic subtract,
    output logic [4*DIGITS-1:0] sum,
    output logic [DIGITS-1:0] digitCarry,
    output logic badDigit
);
    logic [DIGITS:0] carryChain; // decimal carry between cells
    logic [DIGITS-1:0] badMask; // one per digit holding a nibble above nine

    // the carry-in of a subtraction is the +1 of the tens complement
    assign carryChain[0] = subtract;

    ////////////////////////////////////////////////////////////////////////////
    genvar d;
    generate
        for (d = 0; d < DIGITS; d++) begin : gDigit
            logic [3:0] aDig; // accumulator digit
            logic [3:0] bDig; // operand digit
            logic [3:0] bEff; // operand digit or its nines complement
            logic [4:0] rawSum; // plain binary digit sum
            logic over; // digit sum passed nine
            assign aDig = augend[4*d +: 4];
            assign bDig = addend[4*d +: 4];
            // an illegal operand nibble may wrap here; it is flagged anyway
            assign bEff = subtract ? 4'h9 - bDig : bDig;
            assign rawSum = {1'b0, aDig} + {1'b0, bEff} + {4'h0, carryChain[d]};
            assign over = rawSum > 5'h09;
            // decimal correction: skip the six unused codes
            assign sum[4*d +: 4] = over ? 4'(rawSum + 5'h06) : rawSum[3:0];
            assign carryChain[d+1] = over;
            assign digitCarry[d] = over;
            assign badMask[d] = (aDig > 4'h9) | (bDig > 4'h9);
        end
    endgenerate

    // any illegal nibble in either input
    assign badDigit = |badMask;
endmodule

/* core/bcd_accumulator_add_sub_compare.sv */
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "bcd_alu_map.svh"

// Summary of operation
// - compare full accumulator with 32-bit operand
// - less flag set when accumulator below operand
// - equal flag set when values match
// - greater flag set when accumulator above operand
// - single add sums low half with word
// - double add sums accumulator with 32-bit operand
// - single subtract takes word from low half
// - double subtract takes operand from accumulator
// - zero flag follows add/subtract result
// - single add overflow sets 16-bit carry
// - double add overflow sets 32-bit carry
// - single subtract borrow sets 16-bit borrow
// - double subtract borrow sets 32-bit borrow
// - negative flag follows result top bit
// - illegal BCD nibble in an add or subtract input sets invalid-digit flag
// - flags hold until next affecting operation
module bcd_accumulator_add_sub_compare #(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic opStrobe,
    input wire bcd_alu_pkg::op_t opCode,
    input wire bcd_alu_pkg::word_t operand,
    input wire logic [ADDR_WIDTH-1:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdData,
    output bcd_alu_pkg::word_t accValue,
    output logic lessThanFlag,
    output logic equalFlag,
    output logic greaterThanFlag,
    output logic zeroResultFlag,
    output logic borrow16Flag,
    output logic borrow32Flag,
    output logic carry16Flag,
    output logic carry32Flag,
    output logic negativeFlag,
    output logic invalidDigitFlag,
    output logic opDone,
    output logic irq
);
    import bcd_alu_pkg::*;

    localparam int DIGITS = 8; // digits in the accumulator
    localparam int HALF = DIGITS / 2; // digits in a single-width operation

    ////////////////////////////////////////////////////////////////////////////
    // state

    word_t acc_r; // the accumulator
    word_t accNxt;
    logic [`FLAGS_WIDTH-1:0] flags_r; // status flags
    logic [`FLAGS_WIDTH-1:0] flagsNxt;
    logic [`EVT_WIDTH-1:0] evtStatus_r; // sticky events
    logic [`EVT_WIDTH-1:0] evtStatusNxt;
    logic [`EVT_WIDTH-1:0] evtEnable_r; // events allowed onto irq
    logic [`EVT_WIDTH-1:0] evtEnableNxt;
    logic [31:0] rdData_r; // read answer, valid one cycle
    logic opDone_r; // completion pulse
    logic irq_r; // interrupt level

    ////////////////////////////////////////////////////////////////////////////
    // operation decode

    logic isCmp; // double compare
    logic isAdd; // either add width
    logic isSub; // either subtract width
    logic isSingle; // works on the low half only
    logic cmpHit; // compare executes this edge
    logic arithHit; // add or subtract executes this edge
    logic addHit;
    logic subHit;

    assign isCmp = (opCode == COMPARE_DOUBLE_OP);
    assign isAdd = (opCode == BCD_ADD_SINGLE_OP) | (opCode == BCD_ADD_DOUBLE_OP);
    assign isSub = (opCode == BCD_SUBTRACT_SINGLE_OP) | (opCode == BCD_SUBTRACT_DOUBLE_OP);
    assign isSingle = (opCode == BCD_ADD_SINGLE_OP) | (opCode == BCD_SUBTRACT_SINGLE_OP);
    assign cmpHit = opStrobe & isCmp;
    assign addHit = opStrobe & isAdd;
    assign subHit = opStrobe & isSub;
    assign arithHit = addHit | subHit;

    ////////////////////////////////////////////////////////////////////////////
    // decimal datapath

    word_t augendSel; // accumulator, cut to the low half for single width
    word_t addendSel; // operand, cut likewise
    word_t bcdSum; // raw digit result
    logic [DIGITS-1:0] digitCarry; // carry out of each digit
    logic badDigit; // an input held a nibble above nine
    logic carryOut; // decimal carry out of the active width
    word_t resultSel; // value written back to the accumulator

    // single-width work ignores the upper half of both inputs, so its
    // digits can neither raise a carry nor count as illegal
    assign augendSel = isSingle ? {16'h0000, acc_r[15:0]} : acc_r;
    assign addendSel = isSingle ? {16'h0000, operand[15:0]} : operand;

    bcd_digit_adder #(
        .DIGITS(DIGITS)
    ) uDigitAdder (
        .augend(augendSel),
        .addend(addendSel),
        .subtract(isSub),
        .sum(bcdSum),
        .digitCarry(digitCarry),
        .badDigit(badDigit)
    );

    // carry for add, inverted borrow for subtract
    assign carryOut = isSingle ? digitCarry[HALF-1] : digitCarry[DIGITS-1];
    // a single-width result clears the upper half of the accumulator;
    // a negative difference is left in tens complement form
    assign resultSel = isSingle ? {16'h0000, bcdSum[15:0]} : bcdSum;

    ////////////////////////////////////////////////////////////////////////////
    // compare: plain unsigned binary, the operand may hold any hex digits

    logic accBelow;
    logic accMatch;
    assign accBelow = acc_r < operand;
    assign accMatch = acc_r == operand;

    ////////////////////////////////////////////////////////////////////////////
    // register port decode

    logic selAcc;
    logic selFlags;
    logic selEvtStatus;
    logic selEvtClear;
    logic selEvtEnable;
    logic [`EVT_WIDTH-1:0] clearMask; // write-one-to-clear bits
    logic [`EVT_WIDTH-1:0] evtSet; // events raised this edge
    logic [31:0] rdSel; // value presented on the next cycle

    assign selAcc = regAddr == ADDR_WIDTH'(`OFS_ACCUMULATOR);
    assign selFlags = regAddr == ADDR_WIDTH'(`OFS_FLAGS);
    assign selEvtStatus = regAddr == ADDR_WIDTH'(`OFS_EVENT_STATUS);
    assign selEvtClear = regAddr == ADDR_WIDTH'(`OFS_EVENT_CLEAR);
    assign selEvtEnable = regAddr == ADDR_WIDTH'(`OFS_EVENT_ENABLE);
    assign clearMask = (regWrite & selEvtClear) ? regWrData[`EVT_WIDTH-1:0] : `EVENT_RESET;

    // unmapped and write-only offsets read as zero
    assign rdSel = selAcc ? acc_r :
                   selFlags ? {22'h000000, flags_r} :
                   selEvtStatus ? {29'h00000000, evtStatus_r} :
                   selEvtEnable ? {29'h00000000, evtEnable_r} : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // next values

    // an add or subtract wins over a software load in the same cycle
    assign accNxt = arithHit ? resultSel :
                    (regWrite & selAcc) ? regWrData : acc_r;

    // compare touches only the three relation flags
    assign flagsNxt[`FLG_LESS] = cmpHit ? accBelow : flags_r[`FLG_LESS];
    assign flagsNxt[`FLG_EQUAL] = cmpHit ? accMatch : flags_r[`FLG_EQUAL];
    assign flagsNxt[`FLG_GREATER] = cmpHit ? ~accBelow & ~accMatch : flags_r[`FLG_GREATER];
    // add and subtract share zero, negative and invalid digit
    assign flagsNxt[`FLG_ZERO] = arithHit ? (resultSel == 32'h0000_0000) : flags_r[`FLG_ZERO];
    assign flagsNxt[`FLG_NEGATIVE] = arithHit ? resultSel[31] : flags_r[`FLG_NEGATIVE];
    assign flagsNxt[`FLG_BAD_DIGIT] = arithHit ? badDigit : flags_r[`FLG_BAD_DIGIT];
    // both carry flags belong to add; only the active width can set
    assign flagsNxt[`FLG_CARRY16] = addHit ? isSingle & carryOut : flags_r[`FLG_CARRY16];
    assign flagsNxt[`FLG_CARRY32] = addHit ? ~isSingle & carryOut : flags_r[`FLG_CARRY32];
    // both borrow flags belong to subtract; a missing carry is a borrow
    assign flagsNxt[`FLG_BORROW16] = subHit ? isSingle & ~carryOut : flags_r[`FLG_BORROW16];
    assign flagsNxt[`FLG_BORROW32] = subHit ? ~isSingle & ~carryOut : flags_r[`FLG_BORROW32];

    // interrupt sources: every completion, every carry or borrow, bad input
    assign evtSet[`EVT_DONE] = opStrobe;
    assign evtSet[`EVT_OVERFLOW] = (addHit & carryOut) | (subHit & ~carryOut);
    assign evtSet[`EVT_BAD_DIGIT] = arithHit & badDigit;
    // the set term is ORed last so an event in a clearing cycle survives
    assign evtStatusNxt = (evtStatus_r & ~clearMask) | evtSet;
    assign evtEnableNxt = (regWrite & selEvtEnable) ? regWrData[`EVT_WIDTH-1:0] : evtEnable_r;

    ////////////////////////////////////////////////////////////////////////////
    // accumulator and flags move on the same edge

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            acc_r <= `ACC_RESET;
            flags_r <= `FLAGS_RESET;
        end else begin
            acc_r <= accNxt;
            flags_r <= flagsNxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event, enable and interrupt state

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            evtStatus_r <= `EVENT_RESET;
            evtEnable_r <= `EVENT_RESET;
            irq_r <= 1'b0;
            opDone_r <= 1'b0;
        end else begin
            evtStatus_r <= evtStatusNxt;
            evtEnable_r <= evtEnableNxt;
            // built from next values so irq tracks status with no lag
            irq_r <= |(evtStatusNxt & evtEnableNxt);
            opDone_r <= opStrobe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read answer: only the cycle after regRead, zero otherwise

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rdData_r <= `RDATA_RESET;
        end else begin
            rdData_r <= regRead ? rdSel : `RDATA_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, each straight from a flop

    assign regRdData = rdData_r;
    assign accValue = acc_r;
    assign lessThanFlag = flags_r[`FLG_LESS];
    assign equalFlag = flags_r[`FLG_EQUAL];
    assign greaterThanFlag = flags_r[`FLG_GREATER];
    assign zeroResultFlag = flags_r[`FLG_ZERO];
    assign borrow16Flag = flags_r[`FLG_BORROW16];
    assign borrow32Flag = flags_r[`FLG_BORROW32];
    assign carry16Flag = flags_r[`FLG_CARRY16];
    assign carry32Flag = flags_r[`FLG_CARRY32];
    assign negativeFlag = flags_r[`FLG_NEGATIVE];
    assign invalidDigitFlag = flags_r[`FLG_BAD_DIGIT];
    assign opDone = opDone_r;
    assign irq = irq_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    // operation issue patterns
    sequence seqCompare;
        opStrobe && opCode == COMPARE_DOUBLE_OP;
    endsequence
    sequence seqAdd16Wrap;
        opStrobe && opCode == BCD_ADD_SINGLE_OP && acc_r[15:0] == 16'h9999 && operand[15:0] == 16'h0001;
    endsequence
    sequence seqAdd16Plain;
        opStrobe && opCode == BCD_ADD_SINGLE_OP && acc_r == 32'h1234_0005 && operand == 32'h0000_0007;
    endsequence
    sequence seqAdd32;
        opStrobe && opCode == BCD_ADD_DOUBLE_OP && acc_r == 32'h9999_9999 && operand == 32'h0000_0002;
    endsequence
    sequence seqSub16Plain;
        opStrobe && opCode == BCD_SUBTRACT_SINGLE_OP && acc_r == 32'h0000_0050 && operand == 32'h0000_0025;
    endsequence
    sequence seqSub16Under;
        opStrobe && opCode == BCD_SUBTRACT_SINGLE_OP && acc_r[15:0] == 16'h0000 && operand[15:0] == 16'h0001;
    endsequence
    sequence seqSub32Under;
        opStrobe && opCode == BCD_SUBTRACT_DOUBLE_OP && acc_r == 32'h0000_0000 && operand == 32'h0000_0001;
    endsequence

    AST_CMP_LESS: assert property (seqCompare and (acc_r < operand) |=>
        lessThanFlag && !equalFlag && !greaterThanFlag)
        else $error("less flag wrong after compare");
    AST_CMP_EQUAL: assert property (seqCompare and (acc_r == operand) |=>
        equalFlag && !lessThanFlag && !greaterThanFlag)
        else $error("equal flag wrong after compare");
    AST_CMP_GREATER: assert property (seqCompare and (acc_r > operand) |=>
        greaterThanFlag && !lessThanFlag && !equalFlag)
        else $error("greater flag wrong after compare");
    AST_CMP_KEEPS_ACC: assert property (seqCompare |=>
        $stable(accValue) && $stable(zeroResultFlag) && $stable(carry32Flag))
        else $error("compare disturbed accumulator or arithmetic flags");
    AST_ADD16_SUM: assert property (seqAdd16Plain |=>
        accValue == 32'h0000_0012 && !carry16Flag && !zeroResultFlag)
        else $error("single add gave wrong sum");
    AST_ADD16_CARRY: assert property (seqAdd16Wrap |=>
        carry16Flag && !carry32Flag && zeroResultFlag && accValue == 32'h0000_0000)
        else $error("single add carry or zero wrong");
    AST_ADD32_CARRY: assert property (seqAdd32 |=>
        carry32Flag && !carry16Flag && accValue == 32'h0000_0001 && !zeroResultFlag)
        else $error("double add carry or sum wrong");
    AST_SUB16_DIFF: assert property (seqSub16Plain |=>
        accValue == 32'h0000_0025 && !borrow16Flag && !negativeFlag)
        else $error("single subtract gave wrong difference");
    AST_SUB16_BORROW: assert property (seqSub16Under |=>
        borrow16Flag && !borrow32Flag && accValue == 32'h0000_9999)
        else $error("single subtract borrow wrong");
    AST_SUB32_BORROW: assert property (seqSub32Under |=>
        borrow32Flag && negativeFlag && accValue == 32'h9999_9999)
        else $error("double subtract borrow or sign wrong");
    AST_BAD_DIGIT: assert property (arithHit && operand[3:0] > 4'h9 |=>
        invalidDigitFlag ##1 (invalidDigitFlag || $past(arithHit)))
        else $error("illegal digit not flagged");
    AST_FLAGS_HOLD: assert property (!opStrobe |=> $stable(flags_r))
        else $error("flags changed without an operation");
    AST_DONE_PULSE: assert property (opStrobe |=> opDone && $past(opStrobe))
        else $error("completion pulse missing");
    AST_IRQ_LEVEL: assert property (irq == |(evtStatus_r & evtEnable_r))
        else $error("interrupt level disagrees with enabled status");
endmodule

/* tb/bcd_accumulator_add_sub_compare_tb.sv */
`timescale 1ns/100ps
`include "bcd_alu_map.svh"
module bcd_accumulator_add_sub_compare_tb;
    import bcd_alu_pkg::*;
    // one note per strobed operation: expected accumulator and flags
    typedef struct {word_t acc; logic [9:0] flags; logic [9:0] mask; logic accKnown;} opNote_t;
    logic clk_sys, reset_n, opStrobe, regWrite, regRead, rdPend; // bench-driven inputs and read tracker
    op_t opCode;
    word_t operand, accValue, accModel;
    logic [7:0] regAddr;
    logic [31:0] regWrData, regRdData;
    logic lessThanFlag, equalFlag, greaterThanFlag, zeroResultFlag, borrow16Flag, borrow32Flag;
    logic carry16Flag, carry32Flag, negativeFlag, invalidDigitFlag, opDone, irq;
    logic [9:0] flagModel, knownMask; // knownMask drops bits whose value a bad digit leaves open
    int error_cnt, checks, cycleCnt;
    integer seed;
    opNote_t opQ[$];
    logic [31:0] rdQ[$];
    wire logic [9:0] flagsSeen;
    assign flagsSeen = {invalidDigitFlag, negativeFlag, carry32Flag, carry16Flag, borrow32Flag,
                        borrow16Flag, zeroResultFlag, greaterThanFlag, equalFlag, lessThanFlag};

    bcd_accumulator_add_sub_compare dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .opStrobe(opStrobe),
        .opCode(opCode), .operand(operand), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdData), .accValue(accValue), .lessThanFlag(lessThanFlag),
        .equalFlag(equalFlag), .greaterThanFlag(greaterThanFlag), .zeroResultFlag(zeroResultFlag),
        .borrow16Flag(borrow16Flag), .borrow32Flag(borrow32Flag), .carry16Flag(carry16Flag),
        .carry32Flag(carry32Flag), .negativeFlag(negativeFlag), .invalidDigitFlag(invalidDigitFlag),
        .opDone(opDone), .irq(irq));

    ////////////////////////////////////////////////////////////////////////
    // clock at 50 ns period
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // single comparison point: counts every check and reports a mismatch
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // reference digit ripple; subtract adds the nines complement plus one, borrow is no carry out
    function automatic logic [32:0] bcdCalc(input word_t a, input word_t b, input bit sub, input int nd);
        int c;
        int d;
        word_t r;
        c = sub;
        r = '0;
        for (int i = 0; i < nd; i++) begin
            d = a[4*i+:4] + (sub ? 9 - b[4*i+:4] : b[4*i+:4]) + c;
            c = (d > 9);
            r[4*i+:4] = 4'(c ? d - 10 : d);
        end
        return {1'(c), r};
    endfunction

    // any illegal nibble in the used digits of either input
    function automatic bit badDigit(input word_t a, input word_t b, input int nd);
        for (int i = 0; i < nd; i++)
            if (a[4*i+:4] > 9 || b[4*i+:4] > 9)
                return 1'b1;
        return 1'b0;
    endfunction

    function automatic word_t randBcd(input int nd);
        word_t v;
        v = '0;
        for (int i = 0; i < nd; i++)
            v[4*i+:4] = 4'($unsigned($random(seed)) % 10);
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // every driver goes through here: all inputs change together just after a rising edge
    task automatic drive(input logic st, input op_t op, input word_t opnd, input logic wr, input logic rd,
                         input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        opStrobe <= st;
        opCode <= op;
        operand <= opnd;
        regWrite <= wr;
        regRead <= rd;
        regAddr <= a;
        regWrData <= d;
    endtask

    task automatic idle();
        drive(1'b0, COMPARE_DOUBLE_OP, '0, 1'b0, 1'b0, 8'h00, 32'h0);
    endtask

    task automatic regWr(input logic [7:0] a, input logic [31:0] d);
        if (a == `OFS_ACCUMULATOR)
            accModel = d;
        drive(1'b0, COMPARE_DOUBLE_OP, '0, 1'b1, 1'b0, a, d);
    endtask

    task automatic regRd(input logic [7:0] a, input logic [31:0] exp);
        rdQ.push_back(exp);
        drive(1'b0, COMPARE_DOUBLE_OP, '0, 1'b0, 1'b1, a, 32'h0);
    endtask

    // models one operation, notes the expected outcome, then strobes it
    task automatic doOp(input op_t op, input word_t opnd);
        opNote_t n;
        logic [32:0] r;
        logic [9:0] wr;
        int nd;
        bit sub, bad;
        nd = (op == BCD_ADD_SINGLE_OP || op == BCD_SUBTRACT_SINGLE_OP) ? 4 : 8;
        sub = (op == BCD_SUBTRACT_SINGLE_OP || op == BCD_SUBTRACT_DOUBLE_OP);
        bad = (op != COMPARE_DOUBLE_OP) && badDigit(accModel, opnd, nd);
        r = bcdCalc(accModel, opnd, sub, nd);
        wr = (op == COMPARE_DOUBLE_OP) ? 10'h007 : (op > BCD_SUBTRACT_DOUBLE_OP) ? 10'h000 : sub ? 10'h338 : 10'h3c8;
        if (op == COMPARE_DOUBLE_OP)
            flagModel[2:0] = {accModel > opnd, accModel == opnd, accModel < opnd};
        else if (wr != 10'h000) begin
            flagModel[9:8] = {bad, r[31]};
            flagModel[3] = (r[31:0] == 32'h0);
            if (sub)
                flagModel[5:4] = {nd == 8 && !r[32], nd == 4 && !r[32]};
            else
                flagModel[7:6] = {nd == 8 && r[32], nd == 4 && r[32]};
            accModel = r[31:0];
        end
        // after an illegal digit, of the flags the operation writes only the invalid flag is defined
        knownMask = bad ? ((knownMask & ~wr) | 10'h200) : (knownMask | wr);
        n.acc = accModel;
        n.flags = flagModel;
        n.mask = knownMask;
        n.accKnown = !bad;
        opQ.push_back(n);
        drive(1'b1, op, opnd, 1'b0, 1'b0, 8'h00, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watcher: takes the oldest note whenever a completion appears, the oldest expected read whenever read data appears
    always @(posedge clk_sys)
        rdPend <= regRead && reset_n;

    always @(negedge clk_sys) begin : watcher
        opNote_t n;
        if (reset_n && opDone) begin
            if (opQ.size() == 0)
                chk("unexpected done", 32'h1, 32'h0);
            else begin
                n = opQ.pop_front();
                chk("flags", flagsSeen & n.mask, n.flags & n.mask);
                if (n.accKnown)
                    chk("accumulator", accValue, n.acc);
            end
        end
        if (rdPend)
            chk("read data", regRdData, rdQ.pop_front());
    end

    // hang guard: the whole sequence needs well under a few thousand cycles
    always @(posedge clk_sys) begin
        cycleCnt++;
        if (cycleCnt > 8000) begin
            error_cnt++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {reset_n, opStrobe, regWrite, regRead, regAddr, regWrData, operand} = '0;
        opCode = COMPARE_DOUBLE_OP;
        {error_cnt, checks, cycleCnt} = '0;
        seed = 96469;
        accModel = '0;
        flagModel = '0;
        knownMask = 10'h3ff;
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        idle();
        @(negedge clk_sys);
        chk("reset state", {accValue[21:0], flagsSeen}, 32'h0);
        // reset values, unmapped and write-only reads give zero
        regRd(`OFS_ACCUMULATOR, 32'h0);
        regRd(`OFS_FLAGS, 32'h0);
        regRd(`OFS_EVENT_STATUS, 32'h0);
        regRd(`OFS_EVENT_CLEAR, 32'h0);
        regRd(8'h14, 32'h0);
        // back-to-back operations chaining on each other, then boundary carries and borrows
        regWr(`OFS_ACCUMULATOR, 32'h19);
        doOp(BCD_ADD_DOUBLE_OP, 32'h23);
        doOp(COMPARE_DOUBLE_OP, 32'h42);
        doOp(COMPARE_DOUBLE_OP, 32'h43);
        doOp(COMPARE_DOUBLE_OP, 32'h41);
        doOp(BCD_SUBTRACT_DOUBLE_OP, 32'h42);
        doOp(BCD_SUBTRACT_DOUBLE_OP, 32'h1);
        doOp(BCD_ADD_DOUBLE_OP, 32'h1);
        doOp(BCD_SUBTRACT_SINGLE_OP, 32'h1);
        doOp(BCD_ADD_SINGLE_OP, 32'h1);
        doOp(op_t'(3'h6), 32'h5);
        regRd(`OFS_FLAGS, {22'h0, flagModel});
        regWr(`OFS_FLAGS, 32'h3ff);
        regRd(`OFS_FLAGS, {22'h0, flagModel});
        // upper half is ignored by single ops, so its bad nibble must not count
        regWr(`OFS_ACCUMULATOR, 32'ha000_0009);
        doOp(BCD_ADD_SINGLE_OP, 32'hffff_0001);
        // illegal digits in accumulator or operand, each arithmetic op
        for (int i = 1; i < 5; i++) begin
            regWr(`OFS_ACCUMULATOR, 32'h0000_00a0);
            doOp(op_t'(i), 32'h1);
            regWr(`OFS_ACCUMULATOR, 32'h5);
            doOp(op_t'(i), 32'h0000_000f);
            regWr(`OFS_ACCUMULATOR, 32'h0);
        end
        // plain sums and differences that also make every flag known again
        regWr(`OFS_ACCUMULATOR, 32'h1234_0005);
        doOp(BCD_ADD_SINGLE_OP, 32'h7);
        regWr(`OFS_ACCUMULATOR, 32'h50);
        doOp(BCD_SUBTRACT_SINGLE_OP, 32'h25);
        regWr(`OFS_ACCUMULATOR, 32'h9999_9999);
        doOp(BCD_ADD_DOUBLE_OP, 32'h2);
        // random valid traffic over all five operations
        for (int i = 0; i < 300; i++) begin
            if ($random(seed) % 4 == 0)
                regWr(`OFS_ACCUMULATOR, randBcd(1 + $unsigned($random(seed)) % 8));
            doOp(op_t'($unsigned($random(seed)) % 5), randBcd(1 + $unsigned($random(seed)) % 8));
            if ($random(seed) % 8 == 0)
                regRd(`OFS_FLAGS, {22'h0, flagModel & knownMask});
        end
        // interrupt: enabled overflow event raised, masked, cleared
        regWr(`OFS_EVENT_CLEAR, 32'h7);
        regWr(`OFS_EVENT_ENABLE, 32'h2);
        regWr(`OFS_ACCUMULATOR, 32'h1);
        doOp(BCD_ADD_DOUBLE_OP, 32'h1);
        idle();
        @(negedge clk_sys);
        chk("irq", irq, 32'h0);
        regRd(`OFS_EVENT_STATUS, 32'h1);
        regWr(`OFS_ACCUMULATOR, 32'h9999_9999);
        doOp(BCD_ADD_DOUBLE_OP, 32'h1);
        idle();
        @(negedge clk_sys);
        chk("irq", irq, 32'h1);
        regRd(`OFS_EVENT_STATUS, 32'h3);
        regWr(`OFS_EVENT_ENABLE, 32'h0);
        idle();
        @(negedge clk_sys);
        chk("irq", irq, 32'h0);
        regWr(`OFS_EVENT_ENABLE, 32'h2);
        regWr(`OFS_EVENT_CLEAR, 32'h2);
        idle();
        @(negedge clk_sys);
        chk("irq", irq, 32'h0);
        regRd(`OFS_EVENT_STATUS, 32'h1);
        regRd(`OFS_EVENT_ENABLE, 32'h2);
        // second reset in mid-run clears accumulator and flags
        doOp(BCD_SUBTRACT_DOUBLE_OP, 32'h1);
        // let the completion be seen before reset swallows it
        repeat (2) idle();
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(negedge clk_sys);
        chk("second reset", {accValue[21:0], flagsSeen}, 32'h0);
        repeat (2) idle();
        chk("pending notes", opQ.size() + rdQ.size(), 32'h0);
        summarize();
    end
endmodule
